// file: shared/viu_consts.svh
`ifndef VIU_CONSTS_SVH
`define VIU_CONSTS_SVH
// register byte offsets on the bus
`define VIU_OFF_CPU_STATUS 8'h00
`define VIU_OFF_IRQ_STATUS 8'h04
`define VIU_OFF_PERIPH_EN 8'h08
`define VIU_OFF_PERIPH_FLAG 8'h0C
`define VIU_OFF_CORE_CTRL 8'h10
`define VIU_OFF_CORE_STAT 8'h14
`define VIU_ADDR_LSB 2
`define VIU_ADDR_MSB 7
// bit positions
`define VIU_BIT_GLINT_DIS 4
`define VIU_BIT_EXT 0
`define VIU_BIT_T0OVF 1
`define VIU_BIT_T0EDGE 2
`define VIU_BIT_PERIPH 3
`define VIU_BIT_RXFULL 0
`define VIU_BIT_TXEMPTY 1
`define VIU_BIT_CAPTURE_ONE 2
`define VIU_BIT_CAPTURE_TWO 3
`define VIU_BIT_TIMER_ONE 4
`define VIU_BIT_TIMER_TWO 5
`define VIU_BIT_TIMER_THREE 6
`define VIU_BIT_PORT_B_CHANGE 7
// reset values
`define VIU_RST_GLINT_DIS 1'h1
`define VIU_RST_PFLAG 8'h02
`define VIU_RST_PEN 8'h00
// vector addresses, parameters with plain defaults
`define VIU_VEC_EXT 16'h0008
`define VIU_VEC_T0OVF 16'h0010
`define VIU_VEC_T0EDGE 16'h0018
`define VIU_VEC_PERIPH 16'h0020
`define VIU_PC_W 16
`define VIU_STACK_DEPTH 16
`endif

// file: shared/viu_pkg.sv
package viu_pkg;
	typedef enum logic [1:0] {VIU_SRC_EXT, VIU_SRC_T0OVF, VIU_SRC_T0EDGE,
		VIU_SRC_PERIPH} viu_src_type;
	typedef enum {VIU_IDLE, VIU_DATA} viu_bus_state_type;
endpackage : viu_pkg

// file: shared/viu_stack_if.sv
`timescale 1ns/1ps
`include "viu_consts.svh"
// push/pop port between the controller and its return-address stack
interface viu_stack_if;
	logic push;
	logic pop;
	logic [`VIU_PC_W-1:0] push_data;
	logic [`VIU_PC_W-1:0] top_data;
	logic empty;
	logic full;
	modport ctrl (output push, output pop, output push_data, input top_data, input empty,
		input full);
	modport mem (input push, input pop, input push_data, output top_data, output empty,
		output full);
endinterface : viu_stack_if

// file: verilog/viu_stack.sv
`timescale 1ns/1ps
`include "viu_consts.svh"
// ----------------------------------------
// hardware return-address stack
// ----------------------------------------
module viu_stack #(
	parameter int DEPTH = `VIU_STACK_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	viu_stack_if.mem st
);
	localparam int PW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][`VIU_PC_W-1:0] mem;
		logic [PW-1:0] ptr;
		logic [`VIU_PC_W-1:0] top;
	} viu_stack_state_type;
	viu_stack_state_type st_r, st_nxt;

	// push stores at the pointer, pop hands back the top through a register
	always_comb begin
		st_nxt = st_r;
		if (st.push && st_r.ptr != PW'(DEPTH)) begin
			st_nxt.mem[st_r.ptr[PW-1:0]] = st.push_data;
			st_nxt.top = st.push_data;
			st_nxt.ptr = st_r.ptr + PW'(1);
		end else if (st.pop && st_r.ptr != '0) begin
			st_nxt.ptr = st_r.ptr - PW'(1);
			// top after pop: word below, stale when empty
			st_nxt.top = (st_r.ptr > PW'(1)) ? st_r.mem[st_r.ptr - PW'(2)] : st_r.top;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign st.top_data = st_r.top;
	assign st.empty = (st_r.ptr == '0);
	assign st.full = (st_r.ptr == PW'(DEPTH));
endmodule : viu_stack

// file: verilog/viu_ctrl.sv
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "viu_consts.svh"
// ----------------------------------------
// register map, one aligned word each
// ----------------------------------------
// 0x00 cpu status: bit 4 global disable, set out of reset
// 0x04 irq status: [2:0] ext, overflow and edge flags, [3] peripheral pending, [7:4] enables
// 0x08 peripheral enable: one bit per peripheral flag
// 0x0C peripheral flag: 0 rx full, 1 tx empty, 2-3 captures, 4-6 timers, 7 port-b change
// 0x10 pc last handed to the core, read-only
// 0x14 stack full, stack empty and last vector source, read-only
// other offsets read zero and drop writes
// ----------------------------------------
// timing
// ----------------------------------------
// bus: zero wait states; read data is registered at the address phase, shown in the data phase
// bus: a write lands at the end of its data phase, so a read right behind it still returns the old value
// vector: taken at an instruction boundary; strobe and vector address one cycle later
// return: popped pc and cleared disable bit show one cycle after the return strobe
// pins: a filtered change reaches its flag three to four cycles after the pin moves
// event and software clear in one cycle: the event wins, so no request is lost
// stack: a vector waits while the stack is full rather than overwrite a return address
// core: the load strobe lasts one cycle and the core must take the pc then
// port-b: the eight pins share one flag, software compares levels to find the pin
// ----------------------------------------
// limitations
// ----------------------------------------
// rx full cannot be written by software; only the receive-empty input clears it
// a pin pulse of a single clock is dropped by the filters
// only htrans[1] is looked at, so sequential transfers act like nonsequential ones
// hsize is not checked; every access is taken as a whole word
// the ext pin flags on a falling edge, the timer-zero input on a rising edge
module viu_ctrl #(
	parameter logic [`VIU_PC_W-1:0] VEC_EXT = `VIU_VEC_EXT,
	parameter logic [`VIU_PC_W-1:0] VEC_T0OVF = `VIU_VEC_T0OVF,
	parameter logic [`VIU_PC_W-1:0] VEC_T0EDGE = `VIU_VEC_T0EDGE,
	parameter logic [`VIU_PC_W-1:0] VEC_PERIPH = `VIU_VEC_PERIPH,
	parameter int STACK_DEPTH = `VIU_STACK_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// event sources
	input wire logic ext_irq_pin,
	input wire logic timer_zero_clock_input,
	input wire logic [7:0] port_b_change_pins,
	input wire logic timer_zero_ovf,
	input wire logic timer_one_ovf,
	input wire logic timer_two_ovf,
	input wire logic timer_three_ovf,
	input wire logic tx_empty_evt,
	input wire logic rx_full_evt,
	input wire logic capture_one_evt,
	input wire logic capture_two_evt,
	input wire logic rx_data_reg_empty,
	// core side
	input wire logic [`VIU_PC_W-1:0] core_pc,
	input wire logic core_insn_boundary,
	input wire logic return_from_irq_instr,
	output logic core_irq_req,
	output logic core_load_pc,
	output logic [`VIU_PC_W-1:0] core_pc_nxt,
	output viu_pkg::viu_src_type core_vec_src
);
	import viu_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		// three-flop pin synchronisers, newest sample in bit 0
		logic [2:0] ext_sync;
		logic [2:0] t0ck_sync;
		logic [7:0][2:0] pb_sync;
		// last agreed pin levels, the reference for edge detection
		logic ext_lvl;
		logic t0ck_lvl;
		logic [7:0] pb_lvl;
		// global disable and the flags of the three dedicated vectors
		logic glint_dis;
		logic [3:0] core_flag;
		// peripheral flags and enables, all behind the shared vector
		logic [7:0] pflag;
		logic [7:0] pen;
		// enables of the dedicated vectors; bit 3 is spare
		logic [3:0] core_en;
		// registered strobe, target pc and source toward the core
		logic load_pc;
		logic [`VIU_PC_W-1:0] pc_nxt;
		viu_src_type vec_src;
		// data phase: what the address phase captured
		viu_bus_state_type bst;
		logic bwrite;
		logic [5:0] baddr;
		logic [31:0] rdata;
	} viu_state_type;
	viu_state_type s_r, s_nxt;

	// ----------------------------------------
	// return-address stack
	// ----------------------------------------
	// a full stack holds off further vectors rather than lose the oldest return address
	// one push per vector and one pop per return, nothing else moves the pointer
	viu_stack_if stk ();

	viu_stack #(
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.clk(clk),
		.reset_n(reset_n),
		.st(stk.mem)
	);

	// combinational helpers, all from registered state or same-clock inputs
	logic ext_stable, t0ck_stable;
	logic [7:0] pb_stable;
	logic [7:0] pb_s2;
	logic [3:0] core_pend;
	logic periph_pend;
	logic take;
	logic bus_go;
	logic [31:0] wd;

	// ----------------------------------------
	// pin filters: change counts once stages two and three agree
	// ----------------------------------------
	assign ext_stable = (s_r.ext_sync[1] == s_r.ext_sync[2]);
	assign t0ck_stable = (s_r.t0ck_sync[1] == s_r.t0ck_sync[2]);
	genvar gi;
	for (gi = 0; gi < 8; gi++) begin : g_pb
		// a level only moves once two samples in a row agree, so a glitch is dropped
		assign pb_stable[gi] = (s_r.pb_sync[gi][1] == s_r.pb_sync[gi][2]);
		assign pb_s2[gi] = s_r.pb_sync[gi][2];
	end

	// ----------------------------------------
	// pending terms and vector take
	// ----------------------------------------
	// a return strobe blocks a new vector in the same cycle, so the stack is never
	// pushed and popped together
	// pending terms, peripheral enable gates each flag
	assign periph_pend = |(s_r.pflag & s_r.pen);
	assign core_pend = {periph_pend, s_r.core_flag[2:0] & s_r.core_en[2:0]};
	// only at an instruction boundary, so a two-cycle instruction delays by one
	assign take = !s_r.glint_dis && core_insn_boundary && !return_from_irq_instr
		&& (|core_pend) && !stk.full;
	assign core_irq_req = !s_r.glint_dis && (|core_pend);
	assign bus_go = hsel && hready && htrans[1];
	assign wd = hwdata;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		// every field but load_pc, bst and the synchronisers holds unless a branch below moves it
		s_nxt = s_r;
		s_nxt.load_pc = 1'b0;
		// three-stage synchronisers
		s_nxt.ext_sync = {s_r.ext_sync[1:0], ext_irq_pin};
		s_nxt.t0ck_sync = {s_r.t0ck_sync[1:0], timer_zero_clock_input};
		for (int i = 0; i < 8; i++) begin
			s_nxt.pb_sync[i] = {s_r.pb_sync[i][1:0], port_b_change_pins[i]};
		end
		// filtered levels follow stage three only once stages two and three agree
		if (ext_stable) begin
			s_nxt.ext_lvl = s_r.ext_sync[2];
		end
		if (t0ck_stable) begin
			s_nxt.t0ck_lvl = s_r.t0ck_sync[2];
		end
		for (int i = 0; i < 8; i++) begin
			if (pb_stable[i]) begin
				s_nxt.pb_lvl[i] = s_r.pb_sync[i][2];
			end
		end

		// software writes in the data phase; hardware sets come later and win
		if (s_r.bst == VIU_DATA && s_r.bwrite) begin
			case ({s_r.baddr, 2'b00})
				`VIU_OFF_CPU_STATUS: s_nxt.glint_dis = wd[`VIU_BIT_GLINT_DIS];
				// software may set or clear the dedicated flags here
				`VIU_OFF_IRQ_STATUS: begin
					s_nxt.core_flag[2:0] = wd[2:0];
					s_nxt.core_en = wd[7:4];
				end
				`VIU_OFF_PERIPH_EN: s_nxt.pen = wd[7:0];
				// rx full stays hardware owned, read-only for software
				`VIU_OFF_PERIPH_FLAG: s_nxt.pflag[7:1] = wd[7:1];
				default: ;
			endcase
		end

		// vector response: disable, push, load pc
		if (take) begin
			s_nxt.glint_dis = 1'b1;
			s_nxt.load_pc = 1'b1;
			// fixed priority: ext pin, timer-zero overflow, timer-zero edge, peripherals
			if (core_pend[`VIU_BIT_EXT]) begin
				s_nxt.vec_src = VIU_SRC_EXT;
				s_nxt.pc_nxt = VEC_EXT;
				s_nxt.core_flag[`VIU_BIT_EXT] = 1'b0;
			end else if (core_pend[`VIU_BIT_T0OVF]) begin
				s_nxt.vec_src = VIU_SRC_T0OVF;
				s_nxt.pc_nxt = VEC_T0OVF;
				s_nxt.core_flag[`VIU_BIT_T0OVF] = 1'b0;
			end else if (core_pend[`VIU_BIT_T0EDGE]) begin
				s_nxt.vec_src = VIU_SRC_T0EDGE;
				s_nxt.pc_nxt = VEC_T0EDGE;
				s_nxt.core_flag[`VIU_BIT_T0EDGE] = 1'b0;
			end else begin
				// flags stay set, the handler polls them
				s_nxt.vec_src = VIU_SRC_PERIPH;
				s_nxt.pc_nxt = VEC_PERIPH;
			end
		end else if (return_from_irq_instr && !stk.empty) begin
			// pc back from the stack, disable bit cleared in the same edge
			s_nxt.glint_dis = 1'b0;
			s_nxt.load_pc = 1'b1;
			s_nxt.pc_nxt = stk.top_data;
		end

		// rx full clears once the receive data register is drained
		if (rx_data_reg_empty) begin
			s_nxt.pflag[`VIU_BIT_RXFULL] = 1'b0;
		end

		// event sets ignore enables and disable bit, and beat any clear
		if (ext_stable && !s_r.ext_sync[2] && s_r.ext_lvl) begin
			s_nxt.core_flag[`VIU_BIT_EXT] = 1'b1; // falling edge on the pin
		end
		if (timer_zero_ovf) begin
			s_nxt.core_flag[`VIU_BIT_T0OVF] = 1'b1;
		end
		if (t0ck_stable && s_r.t0ck_sync[2] && !s_r.t0ck_lvl) begin
			s_nxt.core_flag[`VIU_BIT_T0EDGE] = 1'b1; // rising edge
		end
		if (rx_full_evt) begin
			s_nxt.pflag[`VIU_BIT_RXFULL] = 1'b1;
		end
		if (tx_empty_evt) begin
			s_nxt.pflag[`VIU_BIT_TXEMPTY] = 1'b1;
		end
		// port-b flags any filtered change on any of its eight pins
		if (|(pb_stable & (pb_s2 ^ s_r.pb_lvl))) begin
			s_nxt.pflag[`VIU_BIT_PORT_B_CHANGE] = 1'b1;
		end
		// captures and timer overflows are same-clock pulses, no filter needed
		if (timer_three_ovf) begin
			s_nxt.pflag[`VIU_BIT_TIMER_THREE] = 1'b1;
		end
		if (timer_two_ovf) begin
			s_nxt.pflag[`VIU_BIT_TIMER_TWO] = 1'b1;
		end
		if (timer_one_ovf) begin
			s_nxt.pflag[`VIU_BIT_TIMER_ONE] = 1'b1;
		end
		if (capture_two_evt) begin
			s_nxt.pflag[`VIU_BIT_CAPTURE_TWO] = 1'b1;
		end
		if (capture_one_evt) begin
			s_nxt.pflag[`VIU_BIT_CAPTURE_ONE] = 1'b1;
		end

		// ahb-lite address phase capture and read data register
		s_nxt.bst = VIU_IDLE;
		if (bus_go) begin
			s_nxt.bst = VIU_DATA;
			s_nxt.bwrite = hwrite;
			s_nxt.baddr = haddr[`VIU_ADDR_MSB:`VIU_ADDR_LSB];
			// built from the state before this edge, so a write still in its data phase is not yet seen
			s_nxt.rdata = '0;
			case ({haddr[`VIU_ADDR_MSB:`VIU_ADDR_LSB], 2'b00})
				`VIU_OFF_CPU_STATUS: s_nxt.rdata[`VIU_BIT_GLINT_DIS] = s_r.glint_dis;
				`VIU_OFF_IRQ_STATUS: s_nxt.rdata[7:0] = {s_r.core_en,
					periph_pend, s_r.core_flag[2:0]};
				`VIU_OFF_PERIPH_EN: s_nxt.rdata[7:0] = s_r.pen;
				`VIU_OFF_PERIPH_FLAG: s_nxt.rdata[7:0] = s_r.pflag;
				`VIU_OFF_CORE_CTRL: s_nxt.rdata[`VIU_PC_W-1:0] = s_r.pc_nxt;
				`VIU_OFF_CORE_STAT: s_nxt.rdata[3:0] = {stk.full, stk.empty,
					s_r.vec_src};
				default: s_nxt.rdata = '0; // unmapped reads zero, writes dropped
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// the disable bit comes out of reset set, so nothing vectors before software is ready
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.glint_dis <= `VIU_RST_GLINT_DIS;
			s_r.pflag <= `VIU_RST_PFLAG;
			s_r.pen <= `VIU_RST_PEN;
		end else begin
			s_r <= s_nxt;
		end
	end

	// stack pushes the interrupted pc, pops on return
	assign stk.push = take;
	assign stk.push_data = core_pc;
	assign stk.pop = return_from_irq_instr && !take;

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// zero wait states and an always-okay response keep the bus side simple
	// load strobe, target and source are registered, so the strobe and target never glitch; core_irq_req is combinational
	assign hrdata = s_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign core_load_pc = s_r.load_pc;
	assign core_pc_nxt = s_r.pc_nxt;
	assign core_vec_src = s_r.vec_src;
	// periph_pend shows in irq status bit 3 for the handler
endmodule : viu_ctrl

// file: verif/viu_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// core stand-in: program counter and instruction pacing
// ----------------------------------------
module viu_core_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic do_ret,
	input wire logic core_load_pc,
	input wire logic [15:0] core_pc_nxt,
	output logic [15:0] core_pc,
	output logic core_insn_boundary,
	output logic return_from_irq_instr
);
	logic ph_r;
	// two-cycle instructions leave every other cycle without a boundary
	assign core_insn_boundary = !slow || ph_r;
	// the bench decides when the return instruction executes
	assign return_from_irq_instr = do_ret;
	// pc follows a vector or the popped address, else steps per instruction
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ph_r <= 1'b0;
			core_pc <= 16'h0100;
		end else begin
			ph_r <= !ph_r;
			if (core_load_pc) core_pc <= core_pc_nxt;
			else if (core_insn_boundary) core_pc <= core_pc + 16'h0001;
		end
	end
endmodule : viu_core_model

// file: verif/viu_ctrl_asserts.sv
`timescale 1ns/1ps
`include "viu_consts.svh"
module viu_ctrl_chk import viu_pkg::*; #(
	parameter int STACK_DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic core_insn_boundary,
	input wire logic return_from_irq_instr,
	input wire logic core_irq_req,
	input wire logic core_load_pc,
	input wire logic [15:0] core_pc_nxt,
	input wire viu_pkg::viu_src_type core_vec_src
);
	import viu_pkg::*;
	logic [5:0] depth_r;
	logic ret_q;
	// stack depth as seen from the ports; a return with nothing pushed is not checked
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			depth_r <= 6'h00;
			ret_q <= 1'h0;
		end else begin
			ret_q <= return_from_irq_instr;
			if (core_load_pc && !ret_q) depth_r <= depth_r + 6'h01;
			else if (core_load_pc && depth_r != 6'h00) depth_r <= depth_r - 6'h01;
		end
	end
	function automatic logic [15:0] vec_of(viu_src_type s);
		case (s)
			VIU_SRC_EXT: return `VIU_VEC_EXT;
			VIU_SRC_T0OVF: return `VIU_VEC_T0OVF;
			VIU_SRC_T0EDGE: return `VIU_VEC_T0EDGE;
			default: return `VIU_VEC_PERIPH;
		endcase
	endfunction : vec_of
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_take;
		core_irq_req && core_insn_boundary && !return_from_irq_instr && depth_r < STACK_DEPTH
			|=> core_load_pc;
	endproperty
	a_take: assert property (p_take) else $error("take without vector load");
	property p_vec;
		core_load_pc && !$past(return_from_irq_instr) |-> core_pc_nxt == vec_of(core_vec_src);
	endproperty
	a_vec: assert property (p_vec) else $error("wrong vector address");
	property p_dis;
		core_load_pc && !$past(return_from_irq_instr) |-> !core_irq_req;
	endproperty
	a_dis: assert property (p_dis) else $error("request while vectoring");
	property p_once;
		core_load_pc && !$past(return_from_irq_instr)
			|=> !core_load_pc || $past(return_from_irq_instr);
	endproperty
	a_once: assert property (p_once) else $error("second vector while disabled");
	property p_ret;
		return_from_irq_instr && depth_r != 6'h00 |=> core_load_pc;
	endproperty
	a_ret: assert property (p_ret) else $error("return without pc load");
	property p_src;
		core_load_pc |-> $past(core_irq_req && core_insn_boundary) || $past(return_from_irq_instr);
	endproperty
	a_src: assert property (p_src) else $error("pc load without cause");
	property p_ok;
		hreadyout && !hresp;
	endproperty
	a_ok: assert property (p_ok) else $error("bus not ready or error");
	property p_hr;
		!$past(hsel && htrans[1] && hready) |-> $stable(hrdata);
	endproperty
	a_hr: assert property (p_hr) else $error("read data moved without transfer");
	c_per: cover property (core_load_pc && core_vec_src == VIU_SRC_PERIPH);
	c_ext: cover property (core_load_pc && core_vec_src == VIU_SRC_EXT);
	c_ret: cover property (return_from_irq_instr ##1 core_load_pc);
endmodule : viu_ctrl_chk

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "viu_consts.svh"
module tb_top;
	import viu_pkg::*;
	logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, do_ret = 0, slow = 0, rx_empty = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h25;
	logic [10:0] ev = 11'h000;
	logic hreadyout, hresp, core_irq_req, core_load_pc, core_insn_boundary;
	logic return_from_irq_instr;
	logic [15:0] core_pc, core_pc_nxt, pcs;
	viu_src_type core_vec_src;
	int errors = 0, tests_run = 0, loads = 0, n0, n1;
	always #4 clk = ~clk;
	always @(posedge clk) if (core_load_pc === 1'b1) loads++;
	// ev: 0 ext pin low, 1 t0 ovf, 2 t0 input, 3..9 peripheral flags 1..7, 10 rx full
	viu_ctrl dut_u (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_irq_pin(!ev[0]),
		.timer_zero_clock_input(ev[2]), .port_b_change_pins({7'h00, ev[9]}),
		.timer_zero_ovf(ev[1]), .timer_one_ovf(ev[6]), .timer_two_ovf(ev[7]),
		.timer_three_ovf(ev[8]), .tx_empty_evt(ev[3]), .rx_full_evt(ev[10]),
		.capture_one_evt(ev[4]), .capture_two_evt(ev[5]), .rx_data_reg_empty(rx_empty),
		.core_pc, .core_insn_boundary, .return_from_irq_instr, .core_irq_req, .core_load_pc,
		.core_pc_nxt, .core_vec_src);
	viu_core_model core_u (.clk, .reset_n, .slow, .do_ret, .core_load_pc, .core_pc_nxt,
		.core_pc, .core_insn_boundary, .return_from_irq_instr);
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [15:0] vec(input viu_src_type s);
		case (s)
			VIU_SRC_EXT: return `VIU_VEC_EXT;
			VIU_SRC_T0OVF: return `VIU_VEC_T0OVF;
			VIU_SRC_T0EDGE: return `VIU_VEC_T0EDGE;
			default: return `VIU_VEC_PERIPH;
		endcase
	endfunction : vec
	task automatic complete_run;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// one single-word transfer; read data taken at the data-phase edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask : rdc
	// events held long enough to pass the pin filters
	task automatic pulse(input logic [10:0] m);
		@(posedge clk);
		ev <= m;
		repeat (5) @(posedge clk);
		ev <= 11'h000;
		repeat (6) @(posedge clk);
	endtask : pulse
	// pcs keeps the pc the core showed at the take edge
	task automatic wait_load;
		#1;
		n0 = 0;
		while (core_load_pc !== 1'b1 && n0 < 60) begin
			pcs = core_pc;
			@(posedge clk);
			#1;
			n0++;
		end
		chk({31'h0, core_load_pc}, 32'h1);
	endtask : wait_load
	// raise a source while masked, then let it vector, service it and return
	task automatic svc(input viu_src_type s, input logic [10:0] m, input logic [7:0] a,
		input logic [31:0] f);
		bus(1'b1, 8'h00, 32'h10);
		n1 = loads;
		pulse(m);
		rdc(a, f, f);
		chk(loads, n1);
		bus(1'b1, 8'h00, 32'h0);
		wait_load();
		chk({core_vec_src, core_pc_nxt}, {s, vec(s)});
		rdc(8'h10, 32'hFFFF, {16'h0, vec(s)});
		rdc(8'h14, 32'hF, {30'h0, s});
		rdc(8'h00, 32'h10, 32'h10);
		rdc(a, f, (s == VIU_SRC_PERIPH) ? f : 32'h0);
		bus(1'b1, a, (a == 8'h04) ? 32'hF0 : 32'h0);
		@(posedge clk);
		do_ret <= 1'b1;
		@(posedge clk);
		do_ret <= 1'b0;
		wait_load();
		chk(core_pc_nxt, pcs);
		rdc(8'h00, 32'h10, 32'h0);
		rdc(8'h10, 32'hFFFF, {16'h0, pcs});
		rdc(8'h14, 32'hC, 32'h4);
	endtask : svc
	initial begin
		#100000;
		errors++;
		complete_run();
	end
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		rdc(8'h00, 32'h10, 32'h10);
		rdc(8'h0C, 32'hFF, 32'h02);
		rdc(8'h08, 32'hFF, 32'h00);
		rdc(8'h18, 32'hFFFFFFFF, 32'h0);
		repeat (4) begin
			bus(1'b1, 8'h0C, 32'h0);
			seed = xs(seed);
			pulse({1'b0, seed[6:0], 3'h0});
			rdc(8'h0C, 32'hFE, {24'h0, seed[6:0], 1'b0});
		end
		pulse(11'h400);
		bus(1'b1, 8'h0C, 32'h0);
		rdc(8'h0C, 32'h1, 32'h1);
		rx_empty <= 1'b1;
		rdc(8'h0C, 32'h1, 32'h0);
		bus(1'b1, 8'h08, 32'h10);
		bus(1'b1, 8'h04, 32'hF0);
		svc(VIU_SRC_EXT, 11'h001, 8'h04, 32'h1);
		svc(VIU_SRC_T0OVF, 11'h002, 8'h04, 32'h2);
		slow <= 1'b1;
		svc(VIU_SRC_T0EDGE, 11'h004, 8'h04, 32'h4);
		svc(VIU_SRC_PERIPH, 11'h040, 8'h0C, 32'h10);
		complete_run();
	end
endmodule : tb_top
bind viu_ctrl viu_ctrl_chk #(.STACK_DEPTH(STACK_DEPTH)) chk_u (.clk, .reset_n, .hsel, .htrans,
	.hready, .hrdata, .hreadyout, .hresp, .core_insn_boundary, .return_from_irq_instr,
	.core_irq_req, .core_load_pc, .core_pc_nxt, .core_vec_src);
